/* File: inc/ref_ctrl_regs.svh */
// Register offsets, field positions and reset values of the reference control block.
// Assumes inclusion by bare name from the design file.
`ifndef REF_CTRL_REGS_SVH
`define REF_CTRL_REGS_SVH

`define REF_CTRL_OFFSET      12'h000
`define REF_SIDEBAND_OFFSET  12'h004
`define REF_CTRL_RESET       8'h00
`define REF_POWER_BIT        7
`define REF_PIN_BIT          6
`define REF_RANGE_BIT        5
`define REF_SOURCE_BIT       4
`define REF_LEVEL_MSB        3
`define REF_LEVEL_LSB        0
`define REF_CMP_INTERNAL     3'h6
`define REF_PIN_DIR_BIT      0
`define REF_ROUTE_BIT        1
`define REF_CMP_SEL_BIT      2

`endif

/* File: inc/ref_ctrl_pkg.sv */
// Types shared by the reference control block.
// Includes no header; only the design file pulls in the register header.
package ref_ctrl_pkg;
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;
  typedef logic [7:0] ref_ctrl_t;
endpackage

/* File: design/comparator_reference_control.sv */
// Control register and output logic for the resistor-ladder comparator reference.
// Assumes an AXI4-Lite master on aclk and asynchronous pin direction and mode inputs.
// How it works
// - The four-bit level code picks one of sixteen taps in either range.
// - Range select 1 picks the low range, code over 24 of the span.
// - Range select 0 picks the high range, a quarter span plus code over 32 of the span.
// - Bit 7 powers the ladder on when set and down when cleared.
// - Bit 6 routes the reference to the shared analog pin when set.
// - The pin is connected only when direction bit and pin enable are both set.
// - Bit 4 picks the external reference pins when 1 and the analog rails when 0.
// - Bits 3 to 0 hold the level code and drive the tap select directly.
// - Reset clears the whole control register to zero.
// - Wake from sleep leaves the register unchanged since only reset clears it.
// - Reference controls are never gated by comparator mode bits.
// - The comparators take the internal reference only when their field equals 110.
`timescale 1ns/1ps
`default_nettype none
`include "ref_ctrl_regs.svh"

module comparator_reference_control (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output ref_ctrl_pkg::axi_resp_t     s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output ref_ctrl_pkg::axi_resp_t     s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   port_f_direction,
  input  wire logic [2:0]             comparator_config_field,
  output logic                        ref_power_on,
  output logic                        ref_pin_drive_enable,
  output logic                        ref_range_select,
  output logic                        ref_source_select,
  output logic [3:0]                  ref_level_code,
  output logic                        ref_pin_route,
  output logic                        cmp_internal_ref_sel
);
  import ref_ctrl_pkg::*;

  ref_ctrl_t   reference_control_ff;
  logic        aw_held_ff;
  logic [11:0] aw_addr_ff;
  logic        w_held_ff;
  logic [31:0] w_data_ff;
  logic        w_strb0_ff;
  logic        bvalid_ff;
  axi_resp_t   bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  axi_resp_t   rresp_ff;
  logic        dir_meta_ff;
  logic        dir_sync_ff;
  logic [2:0]  cmp_meta_ff;
  logic [2:0]  cmp_sync_ff;
  logic        route_ff;
  logic        cmp_sel_ff;

  // Word decode used for both the write and the read side.
  function automatic logic [1:0] decode_addr(input logic [11:0] addr);
    logic [1:0] hit;
    hit = 2'b00;
    if (addr[11:2] == `REF_CTRL_OFFSET >> 2) begin
      hit = 2'b01;
    end else if (addr[11:2] == `REF_SIDEBAND_OFFSET >> 2) begin
      hit = 2'b10;
    end
    return hit;
  endfunction

  wire        aw_take     = s_axi_awvalid && s_axi_awready;
  wire        w_take      = s_axi_wvalid && s_axi_wready;
  wire        aw_have     = aw_held_ff || aw_take;
  wire        w_have      = w_held_ff || w_take;
  wire        wr_fire     = aw_have && w_have && !bvalid_ff;
  wire [11:0] wr_addr     = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
  wire [31:0] wr_data     = w_held_ff ? w_data_ff : s_axi_wdata;
  wire        wr_strb0    = w_held_ff ? w_strb0_ff : s_axi_wstrb[0];
  wire [1:0]  wr_hit      = decode_addr(wr_addr);
  wire        ctrl_write  = wr_fire && wr_hit[0] && wr_strb0;
  wire        ar_take     = s_axi_arvalid && s_axi_arready;
  wire [1:0]  rd_hit      = decode_addr(s_axi_araddr);
  wire [31:0] side_word   = {29'h0000_0000, cmp_sel_ff, route_ff, dir_sync_ff};
  wire [31:0] rd_word     = rd_hit[0] ? {24'h00_0000, reference_control_ff} :
                            rd_hit[1] ? side_word : 32'h0000_0000;
  wire        nxt_route   = dir_sync_ff && reference_control_ff[`REF_PIN_BIT];
  wire        nxt_cmp_sel = cmp_sync_ff == `REF_CMP_INTERNAL;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Ladder controls come straight from the register, never gated by comparator mode.
  assign ref_power_on         = reference_control_ff[`REF_POWER_BIT];
  assign ref_pin_drive_enable = reference_control_ff[`REF_PIN_BIT];
  assign ref_range_select     = reference_control_ff[`REF_RANGE_BIT];
  assign ref_source_select    = reference_control_ff[`REF_SOURCE_BIT];
  assign ref_level_code       =
    reference_control_ff[`REF_LEVEL_MSB:`REF_LEVEL_LSB];
  assign ref_pin_route        = route_ff;
  assign cmp_internal_ref_sel = cmp_sel_ff;

  // Only reset clears the register; sleep and wake do not touch it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reference_control_ff <= `REF_CTRL_RESET;
    end else if (ctrl_write) begin
      reference_control_ff <= wr_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_meta_ff <= 1'b0;
      dir_sync_ff <= 1'b0;
      cmp_meta_ff <= 3'h0;
      cmp_sync_ff <= 3'h0;
      route_ff    <= 1'b0;
      cmp_sel_ff  <= 1'b0;
    end else begin
      dir_meta_ff <= port_f_direction;
      dir_sync_ff <= dir_meta_ff;
      cmp_meta_ff <= comparator_config_field;
      cmp_sync_ff <= cmp_meta_ff;
      route_ff    <= nxt_route;
      cmp_sel_ff  <= nxt_cmp_sel;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb0_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (wr_hit != 2'b00) ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_ff <= 1'b1;
          aw_addr_ff <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_ff  <= 1'b1;
          w_data_ff  <= s_axi_wdata;
          w_strb0_ff <= s_axi_wstrb[0];
        end
        if (bvalid_ff && s_axi_bready) begin
          bvalid_ff <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= (rd_hit != 2'b00) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Register contents and the ladder controls that follow them.
  chk_write_reaches_outputs: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_write |=> {ref_power_on, ref_pin_drive_enable, ref_range_select,
                    ref_source_select, ref_level_code} == $past(wr_data[7:0]))
    else $error("Control write did not reach the ladder outputs.");
  chk_reset_clears_ctrl: assert property (@(posedge aclk)
    !aresetn |=> reference_control_ff == 8'h00)
    else $error("Reset did not clear the control register.");
  chk_reset_outputs: assert property (@(posedge aclk)
    !aresetn |=> !ref_pin_route && !cmp_internal_ref_sel && !s_axi_bvalid && !s_axi_rvalid)
    else $error("Reset left a routed pin or a pending bus answer.");
  chk_hold_without_write: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_write |=> $stable(reference_control_ff))
    else $error("Control register changed without a write.");
  chk_strobe_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && !wr_strb0 |=> $stable(reference_control_ff))
    else $error("Write without the low byte strobe changed the register.");
  chk_level_code_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    ref_level_code == reference_control_ff[3:0] && ref_range_select == reference_control_ff[5])
    else $error("Tap code or range does not follow the register.");

  // Pin routing and comparator selection.
  chk_pin_route_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ref_pin_route |-> $past(dir_sync_ff) && $past(ref_pin_drive_enable))
    else $error("Pin routed without direction and enable both set.");
  chk_pin_route_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    !ref_pin_drive_enable |=> !ref_pin_route)
    else $error("Pin still routed after the enable bit cleared.");
  chk_pin_route_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    (port_f_direction && ref_pin_drive_enable && !ctrl_write)[*4] |-> ref_pin_route)
    else $error("Pin not routed after direction and enable settled.");
  chk_cmp_mode_select: assert property (@(posedge aclk) disable iff (!aresetn)
    (comparator_config_field == 3'h6)[*3] |=> cmp_internal_ref_sel)
    else $error("Internal reference not selected in mode 110.");
  chk_cmp_mode_other: assert property (@(posedge aclk) disable iff (!aresetn)
    (comparator_config_field != 3'h6)[*3] |=> !cmp_internal_ref_sel)
    else $error("Internal reference selected outside mode 110.");
  chk_power_independent: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(cmp_sync_ff) && !$past(ctrl_write)) |-> $stable(ref_power_on))
    else $error("Power bit moved with comparator mode.");
  chk_fields_independent: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(cmp_sync_ff) && !$past(ctrl_write)) |-> $stable(ref_level_code) &&
      $stable(ref_range_select) && $stable(ref_source_select) && $stable(ref_pin_drive_enable))
    else $error("Ladder fields moved with comparator mode.");

  // Write channel handshake.
  chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("Write response missing one cycle after the write.");
  chk_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped or changed before it was taken.");
  chk_bvalid_drops: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response still valid after it was taken.");
  chk_aw_w_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write channel ready while a response is pending.");
  chk_write_ctrl_okay: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_hit[0] |=> s_axi_bresp == RESP_OKAY)
    else $error("Control write not answered with an okay response.");
  chk_write_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_hit == 2'b00 |=> s_axi_bresp == RESP_SLVERR && $stable(reference_control_ff))
    else $error("Unmapped write not refused.");

  // Read channel handshake.
  chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take |=> s_axi_rvalid)
    else $error("Read data missing one cycle after the address.");
  chk_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped or changed before it was taken.");
  chk_rresp_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rresp))
    else $error("Read response changed before it was taken.");
  chk_rvalid_drops: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read data still valid after it was taken.");
  chk_ar_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address ready while read data is pending.");
  chk_read_ctrl_data: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_hit[0] |=> s_axi_rdata == {24'h00_0000, $past(reference_control_ff)})
    else $error("Control read returned the wrong value.");
  chk_read_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_hit == 2'b00 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("Unmapped read not refused with zero data.");

endmodule
`default_nettype wire

/* File: verification/ref_ladder_model.sv */
// Model of the resistor ladder and shared pin multiplexer behind the block.
// Assumes the block's control outputs drive it directly.
`timescale 1ns/1ps
`default_nettype none
module ref_ladder_model (
  input  wire logic       power_on,
  input  wire logic       range_sel,
  input  wire logic [3:0] level_code,
  input  wire logic       pin_route,
  output logic      [6:0] level_96,
  output logic      [6:0] pin_level
);
  // Levels are in 96ths of the source span, so both ranges stay whole numbers.
  assign level_96 = !power_on ? 7'h00 :
                    range_sel ? {1'b0, level_code, 2'b00} :
                    7'h18 + 7'(level_code) * 7'h03;
  // An unrouted pin is not driven, so it shows the inverse rather than the level.
  assign pin_level = pin_route ? level_96 : ~level_96;
endmodule
`default_nettype wire

/* File: verification/test_comparator_reference_control.sv */
// Self-checking bench for the comparator reference control block.
// Assumes the package, the block and the ladder model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_comparator_reference_control;
  import ref_ctrl_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dir;
  logic        awready, wready, bvalid, arready, rvalid, pwr, pin_en, rng, src;
  logic        route, cmp_sel;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  wstrb, level;
  logic [2:0]  cfg;
  logic [6:0]  level_96, pin_level;
  axi_resp_t   bresp, rresp, resp;
  int          error_cnt = 0;
  int          n_compared = 0;
  wire  [7:0]  outs = {pwr, pin_en, rng, src, level};

  comparator_reference_control uut (.aclk, .aresetn, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .port_f_direction(dir), .comparator_config_field(cfg),
    .ref_power_on(pwr), .ref_pin_drive_enable(pin_en), .ref_range_select(rng),
    .ref_source_select(src), .ref_level_code(level), .ref_pin_route(route),
    .cmp_internal_ref_sel(cmp_sel));
  ref_ladder_model ladder (.power_on(pwr), .range_sel(rng), .level_code(level),
    .pin_route(route), .level_96(level_96), .pin_level(pin_level));

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask

  // Address and data channels drop valid, response channels drop ready, each at its own handshake; a spare edge follows.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input axi_resp_t er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
    cmp({30'h0, resp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input axi_resp_t er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
    cmp(got, ed);
    cmp({30'h0, resp}, {30'h0, er});
  endtask

  task automatic results();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    repeat (3000) @(posedge aclk);
    error_cnt++;
    results();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, dir} = 7'h00;
    {awaddr, araddr, wdata, wstrb, cfg} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h000, 32'h0, RESP_OKAY);
    cmp({24'h0, outs}, 32'h0);
    wr(12'h000, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    rd(12'h000, 32'hFF, RESP_OKAY);
    cmp({24'h0, outs}, 32'hFF);
    cmp({31'h0, route}, 32'h0);
    wr(12'h000, 32'h5A, 4'hE, RESP_OKAY);
    rd(12'h000, 32'hFF, RESP_OKAY);
    for (int i = 0; i < 32; i++) begin
      wr(12'h000, {24'h0, 2'b10, i[4], i[0], i[3:0]}, 4'h1, RESP_OKAY);
      cmp({24'h0, outs}, {24'h0, 2'b10, i[4], i[0], i[3:0]});
      cmp(32'(level_96), i[4] ? 32'(4 * (i % 16)) : 32'(24 + 3 * (i % 16)));
    end
    wr(12'h000, 32'h2F, 4'h1, RESP_OKAY);
    cmp(32'(level_96), 32'h0);
    wr(12'h000, 32'hC8, 4'h1, RESP_OKAY);
    dir <= 1'b1;
    repeat (4) @(posedge aclk);
    cmp({31'h0, route}, 32'h1);
    cmp(32'(pin_level), 32'd48);
    dir <= 1'b0;
    repeat (4) @(posedge aclk);
    cmp({31'h0, route}, 32'h0);
    dir <= 1'b1;
    wr(12'h000, 32'h88, 4'h1, RESP_OKAY);
    cmp({31'h0, route}, 32'h0);
    wr(12'h000, 32'hC8, 4'h1, RESP_OKAY);
    for (int m = 0; m < 8; m++) begin
      cfg <= m[2:0];
      repeat (4) @(posedge aclk);
      cmp({31'h0, cmp_sel}, {31'h0, m == 6});
      cmp({24'h0, outs}, 32'hC8);
      rd(12'h004, {29'h0, m == 6, 2'b11}, RESP_OKAY);
    end
    rd(12'h008, 32'h0, RESP_SLVERR);
    wr(12'h008, 32'h00, 4'hF, RESP_SLVERR);
    wr(12'h004, 32'h00, 4'hF, RESP_OKAY);
    rd(12'h000, 32'hC8, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h000, 32'h0, RESP_OKAY);
    cmp({23'h0, outs, route}, 32'h0);
    results();
  end
endmodule
`default_nettype wire
